// >>> rtl/sba_regs.svh
// offsets, field positions and codes of the shared bus arbiter and host port
// assumes the 21-bit slave address of the shared external bus
`ifndef SBA_REGS_SVH
`define SBA_REGS_SVH
`define SBA_NUM_PROC     6
`define SBA_SPACE_HI     20
`define SBA_SPACE_LO     17
`define SBA_MEM_SEL_BIT  16
`define SBA_OWN_SPACE    4'h0
`define SBA_BCAST_SPACE  4'h7
`define SBA_NONE_CODE    3'h0
`define SBA_HOST_CODE    3'h7
`define SBA_IOP_NUM      16
`define SBA_DMA_NUM      4
`define SBA_DMA_CTRL_OFS 4'h8
`define SBA_MBOX0_OFS    4'h9
`define SBA_MBOX1_OFS    4'hA
`define SBA_VECTOR_OFS   4'hD
`define SBA_SYNC_W       68
`endif

// >>> rtl/sba_pkg.sv
// types of the shared bus arbiter and host port
// assumes nothing beyond the compile order
package sba_pkg;
	typedef enum logic [2:0] {
		SBA_IDLE = 3'b001,
		SBA_READ = 3'b010,
		SBA_DONE = 3'b100
	} sba_state_t;
	typedef logic [2:0] sba_code_t;
endpackage

// >>> rtl/sba_mem.sv
// internal memory of the processor, one port, registered read data
// assumes a single clock shared with the arbiter
module sba_mem #(
	parameter int AW = 10,
	parameter int DW = 32
) (
	input  wire logic          clk_in,
	input  wire logic          we_in,
	input  wire logic [AW-1:0] addr_in,
	input  wire logic [DW-1:0] wdata_in,
	output logic      [DW-1:0] rdata_out
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem[addr_in] <= wdata_in;
		end
		rdata_out <= mem[addr_in];
	end
endmodule

// >>> rtl/sba_arbiter.sv
// shared bus arbitration and host slave port of one processor
// assumes every pin input is asynchronous and is resynchronised here
// Summary of operation
// - up to six peers plus a host share one bus, no glue logic
// - handover of mastership between processors costs at most one bus cycle, from the host to a processor two
// - priority among requesters is fixed or rotating, selectable
// - bus lock keeps mastership across a read then a write
// - interprocessor command raises a vectored interrupt
// - broadcast writes are taken by every processor except the current master at once
// - each processor's internal memory sits in one unified address space
// - host uses request, grant, ready, acknowledge and chip select lines
// - host reads and writes internal memory, DMA setup and mailboxes
// - host accesses decode as memory-mapped locations via external port
// - host data bus may be 16 or 32 bits wide
// - four DMA channels serve the host interface
// - vectored interrupt lets host post commands for execution
// - port, arbitration and host sequencing all run on input clock
`include "sba_regs.svh"
module sba_arbiter #(
	parameter int MEM_AW = 10
) (
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	input  wire logic [2:0]  cfg_id_in,
	input  wire logic        cfg_rotating_in,
	input  wire logic        cfg_host16_in,
	input  wire logic        core_req_in,
	input  wire logic        core_lock_in,
	input  wire logic [5:0]  bus_req_in,
	input  wire logic        host_bus_request_n_in,
	input  wire logic        chip_select_n_in,
	input  wire logic        rd_n_in,
	input  wire logic        wr_n_in,
	input  wire logic [20:0] addr_in,
	input  wire logic [31:0] data_in,
	output logic             bus_req_out,
	output logic             bus_master_out,
	output logic             host_bus_grant_n_out,
	output logic             host_bus_grant_oe_out,
	output logic             host_ready_out,
	output logic             host_ready_oe_out,
	output logic             access_ack_out,
	output logic             access_ack_oe_out,
	output logic [31:0]      data_out,
	output logic             data_oe_out,
	output logic             vector_irq_out,
	output logic [31:0]      vector_addr_out,
	output logic [3:0]       dma_enable_out
);
	function automatic sba_pkg::sba_code_t sba_pick(input logic [5:0] r, input logic [2:0] start);
		logic [2:0] k;
		sba_pick = `SBA_NONE_CODE;
		for (int i = `SBA_NUM_PROC - 1; i >= 0; i--) begin
			k = 3'((32'(start) + i) % `SBA_NUM_PROC);
			if (r[k]) begin
				sba_pick = 3'(k + 3'h1);
			end
		end
	endfunction

	logic [`SBA_SYNC_W-1:0] sync1;
	logic [`SBA_SYNC_W-1:0] sync2;
	logic [2:0]             id;
	logic                   id_valid;
	logic [1:0]             warm;
	sba_pkg::sba_code_t     master;
	logic [2:0]             last_idx;
	sba_pkg::sba_state_t    state;
	logic                   half;
	logic [15:0]            low_half;
	logic                   is_read;
	logic                   host_acc;
	logic [31:0]            iop [0:`SBA_IOP_NUM-1];
	logic [5:0]             prev_reqs;

	// pin resynchronisation, input clock only
	// input clock domain
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {cfg_id_in, cfg_rotating_in, cfg_host16_in, bus_req_in, host_bus_request_n_in,
				chip_select_n_in, rd_n_in, wr_n_in, addr_in, data_in};
			sync2 <= sync1;
		end
	end

	logic [2:0]  s_id;
	logic        s_rot;
	logic        s_h16;
	logic [5:0]  reqs;
	logic        host_req;
	logic        cs;
	logic        rd;
	logic        wr;
	logic [20:0] addr;
	logic [31:0] wdata;
	logic [3:0]  space;
	always_comb begin
		s_id     = sync2[67:65];
		s_rot    = sync2[64];
		s_h16    = sync2[63];
		reqs     = sync2[62:57];
		host_req = !sync2[56];
		cs       = !sync2[55];
		rd       = !sync2[54];
		wr       = !sync2[53];
		addr     = sync2[52:32];
		wdata    = sync2[31:0];
		space    = addr[`SBA_SPACE_HI:`SBA_SPACE_LO];
	end

	// arbitration
	sba_pkg::sba_code_t next_master;
	logic [2:0]         next_last_idx;
	logic [2:0]         next_id;
	logic               next_id_valid;
	logic [1:0]         next_warm;
	logic               next_bus_req;
	logic               cur_proc;
	logic               cur_req;
	logic [5:0]         others;
	logic [2:0]         rot_start;
	always_comb begin
		// id strap read only once it has crossed both sync stages
		next_warm     = warm[1] ? warm : 2'(warm + 2'h1);
		next_id       = id;
		next_id_valid = id_valid || warm[1];
		if (!id_valid && warm[1]) begin
			next_id = s_id;
		end
		cur_proc      = master != `SBA_NONE_CODE && master != `SBA_HOST_CODE;
		cur_req       = cur_proc && reqs[3'(master - 3'h1)];
		others        = reqs;
		if (cur_proc) begin
			others[3'(master - 3'h1)] = 1'b0;
		end
		rot_start     = (last_idx == 3'(`SBA_NUM_PROC - 1)) ? 3'h0 : 3'(last_idx + 3'h1);
		next_master   = master;
		next_last_idx = last_idx;
		next_bus_req  = core_req_in || core_lock_in;
		if (id_valid) begin
			// distributed, identical decision in every processor
			// next master picked on the release edge
			if (master == `SBA_HOST_CODE) begin
				if (!host_req) begin
					next_master = `SBA_NONE_CODE;
				end
			end else if (!cur_req) begin
				// host waits for the current master to release
				if (host_req) begin
					next_master = `SBA_HOST_CODE;
				end else begin
					next_master = sba_pick(others, s_rot ? rot_start : 3'h0);
				end
			end
			if (next_master != `SBA_NONE_CODE && next_master != `SBA_HOST_CODE) begin
				next_last_idx = 3'(next_master - 3'h1);
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			id                   <= 3'h0;
			id_valid             <= 1'b0;
			warm                 <= 2'h0;
			master               <= `SBA_NONE_CODE;
			last_idx             <= 3'h0;
			bus_req_out          <= 1'b0;
			bus_master_out       <= 1'b0;
			host_bus_grant_n_out <= 1'b1;
			prev_reqs            <= 6'h00;
		end else begin
			id                   <= next_id;
			id_valid             <= next_id_valid;
			warm                 <= next_warm;
			master               <= next_master;
			last_idx             <= next_last_idx;
			bus_req_out          <= next_bus_req;
			bus_master_out       <= id_valid && next_master == id;
			host_bus_grant_n_out <= next_master != `SBA_HOST_CODE;
			prev_reqs            <= reqs;
		end
	end

	// processor one drives the host grant line
	assign host_bus_grant_oe_out = id_valid && id == 3'h1;

	// slave access decode
	logic host_sel;
	logic peer_sel;
	logic sel;
	logic in_mem;
	logic vec_hit;
	always_comb begin
		// host space is the all-zero select field
		host_sel = master == `SBA_HOST_CODE && cs && space == `SBA_OWN_SPACE;
		// own window in the unified space
		// broadcast write hits every processor but the current master together
		peer_sel = cur_proc && master != id && (space == {1'b0, id} || (space == `SBA_BCAST_SPACE && wr));
		sel      = id_valid && (host_sel || peer_sel) && (rd || wr);
		in_mem   = addr[`SBA_MEM_SEL_BIT];
		vec_hit  = state == sba_pkg::SBA_IDLE && sel && wr && !in_mem && addr[3:0] == `SBA_VECTOR_OFS;
	end

	logic              mem_we;
	logic [31:0]       mem_wdata;
	logic [31:0]       mem_rdata;
	logic              wide;
	logic              full_word;
	always_comb begin
		// 16-bit host pairs two halves, low first
		wide      = !(host_sel && s_h16);
		full_word = wide || half;
		mem_wdata = wide ? wdata : {wdata[15:0], low_half};
		mem_we    = state == sba_pkg::SBA_IDLE && sel && wr && in_mem && full_word;
	end

	sba_mem #(.AW(MEM_AW), .DW(32)) u_mem (
		.clk_in    (clk_in),
		.we_in     (mem_we),
		.addr_in   (addr[MEM_AW-1:0]),
		.wdata_in  (mem_wdata),
		.rdata_out (mem_rdata)
	);

	// access sequencing
	sba_pkg::sba_state_t next_state;
	logic                next_half;
	logic [15:0]         next_low_half;
	logic                next_is_read;
	logic                next_host_acc;
	logic [31:0]         next_data;
	logic [31:0]         rword;
	always_comb begin
		next_state    = state;
		next_half     = half;
		next_low_half = low_half;
		next_is_read  = is_read;
		next_host_acc = host_acc;
		next_data     = data_out;
		rword         = in_mem ? mem_rdata : iop[addr[3:0]];
		case (state)
			sba_pkg::SBA_IDLE: begin
				if (sel) begin
					next_is_read  = rd;
					next_host_acc = host_sel;
					// read goes through a memory cycle
					if (rd) begin
						next_state = sba_pkg::SBA_READ;
					end else begin
						next_state = sba_pkg::SBA_DONE;
						if (!wide) begin
							next_half     = !half;
							next_low_half = half ? low_half : wdata[15:0];
						end
					end
				end
			end
			sba_pkg::SBA_READ: begin
				next_state = sba_pkg::SBA_DONE;
				if (wide) begin
					next_data = rword;
				end else begin
					next_data = {16'h0000, half ? rword[31:16] : rword[15:0]};
					next_half = !half;
				end
			end
			sba_pkg::SBA_DONE: begin
				if (!rd && !wr) begin
					next_state = sba_pkg::SBA_IDLE;
				end
			end
			default: begin
				next_state = sba_pkg::SBA_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state    <= sba_pkg::SBA_IDLE;
			half     <= 1'b0;
			low_half <= 16'h0000;
			is_read  <= 1'b0;
			host_acc <= 1'b0;
			data_out <= 32'h00000000;
		end else begin
			state    <= next_state;
			half     <= next_half;
			low_half <= next_low_half;
			is_read  <= next_is_read;
			host_acc <= next_host_acc;
			data_out <= next_data;
		end
	end

	// ready driven low only in the read state of a host read
	assign host_ready_out    = 1'b0;
	assign host_ready_oe_out = host_acc && state == sba_pkg::SBA_READ;
	assign access_ack_out    = state == sba_pkg::SBA_DONE;
	assign access_ack_oe_out = state != sba_pkg::SBA_IDLE;
	assign data_oe_out       = state == sba_pkg::SBA_DONE && is_read;

	// DMA setup, mailbox and vector registers
	logic        iop_we;
	logic [31:0] next_vector_addr;
	always_comb begin
		iop_we           = state == sba_pkg::SBA_IDLE && sel && wr && !in_mem && full_word;
		next_vector_addr = vector_addr_out;
		if (vec_hit && full_word) begin
			next_vector_addr = mem_wdata;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < `SBA_IOP_NUM; i++) begin
				iop[i] <= 32'h00000000;
			end
			vector_irq_out  <= 1'b0;
			vector_addr_out <= 32'h00000000;
		end else begin
			// host writes DMA setup and mailboxes
			if (iop_we) begin
				iop[addr[3:0]] <= mem_wdata;
			end
			// command from a peer or host
			vector_irq_out  <= vec_hit && full_word;
			vector_addr_out <= next_vector_addr;
		end
	end

	assign dma_enable_out = iop[`SBA_DMA_CTRL_OFS][`SBA_DMA_NUM-1:0];

	logic [2:0] fixed_win;
	assign fixed_win = sba_pick(reqs, 3'h0);

	new_master_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(master != $past(master) && master != `SBA_NONE_CODE && master != `SBA_HOST_CODE)
		|-> prev_reqs[3'(master - 3'h1)])
		else $error("new master had no request");
	changeover_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(id_valid && cur_proc && !cur_req && |others && !host_req) |=> master != `SBA_NONE_CODE)
		else $error("handover took more than one cycle");
	fixed_prio_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(id_valid && !s_rot && master == `SBA_NONE_CODE && |reqs && !host_req) |=> master == $past(fixed_win))
		else $error("fixed priority winner wrong");
	lock_req_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		core_lock_in |=> bus_req_out)
		else $error("lock dropped bus request");
	vector_pulse_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(vec_hit && full_word) |=> vector_irq_out ##1 !vector_irq_out)
		else $error("vector interrupt not one pulse");
	bcast_take_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(state == sba_pkg::SBA_IDLE && id_valid && cur_proc && master != id && space == `SBA_BCAST_SPACE && wr)
		|=> state == sba_pkg::SBA_DONE)
		else $error("broadcast write not taken");
	host_grant_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		$fell(host_bus_grant_n_out) |-> $past(host_req))
		else $error("grant without host request");
	host_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(state == sba_pkg::SBA_IDLE && sel && rd) |=> host_ready_oe_out == host_sel ##1 access_ack_out && data_oe_out)
		else $error("read answer timing wrong");
	half_pair_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(state == sba_pkg::SBA_IDLE && sel && wr && !wide && !half) |-> !mem_we && !iop_we)
		else $error("first half written early");
endmodule

// >>> tb/sba_far_model.sv
// far side of the shared bus: one host and the peers with ids 2..6
// assumes the device is processor 1 and samples every pin on clk_in
module sba_far_model (
	input  wire logic        clk_in,
	input  wire logic        grant_n_in,
	input  wire logic        ack_in,
	input  wire logic [31:0] rdata_in,
	output logic             hbr_n_out,
	output logic             cs_n_out,
	output logic             rd_n_out,
	output logic             wr_n_out,
	output logic [20:0]      addr_out,
	output logic [31:0]      data_out,
	output logic [6:2]       peer_req_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		hbr_n_out = 1'b1;
		cs_n_out = 1'b1;
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		addr_out = 21'h1FFFFF;
		data_out = 32'h0;
		peer_req_out = 5'h00;
	end
	task automatic peer(input logic [6:2] r);
		@(negedge clk_in);
		peer_req_out = r;
	endtask
	task automatic host_get(input bit rq, input int n, output bit ok);
		@(negedge clk_in);
		hbr_n_out = !rq;
		ok = 0;
		for (int i = 0; i < n && !ok; i++) begin
			@(posedge clk_in);
			ok = !grant_n_in;
		end
	endtask
	// select field driven, strobes held until acknowledge or for at most 20 clocks
	task automatic xfer(input bit rd, input bit host, input logic [20:0] a, input logic [31:0] d,
		output logic [31:0] q, output bit ok);
		@(negedge clk_in);
		addr_out = a;
		data_out = rd ? ~d : d;
		cs_n_out = !host;
		rd_n_out = !rd;
		wr_n_out = rd;
		ok = 0;
		q = 32'h0;
		for (int i = 0; i < 20 && !ok; i++) begin
			@(posedge clk_in);
			ok = ack_in;
			q = rdata_in;
		end
		@(negedge clk_in);
		cs_n_out = 1'b1;
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		// released lines show no stale value
		addr_out = ~a;
		data_out = ~data_out;
		repeat (4) @(posedge clk_in);
	endtask
endmodule

// >>> tb/shared_bus_arbitration_host_port_tb.sv
// self-checking bench of the shared bus arbiter and host port
// assumes the device strapped as processor 1, so it drives the host grant
`include "sba_regs.svh"
module shared_bus_arbitration_host_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in, resetn_in, core_req_in, core_lock_in, cfg_rotating_in, cfg_host16_in;
	logic        hbr_n, cs_n, rd_n, wr_n, bus_req_out, bus_master_out, grant_n, grant_oe;
	logic        rdy, rdy_oe, ack, ack_oe, rdata_oe, irq;
	logic [6:2]  peer_req;
	logic [20:0] addr, ta;
	logic [31:0] wdata, rdata, vec, q, d;
	logic [3:0]  dma;
	wire logic   grant_w = grant_oe ? grant_n : 1'b1;
	wire logic   ack_w = ack_oe & ack;
	bit          ok;
	int          error_cnt, n_tests, irq_cnt, rdy_cnt, seed, i;
	logic [31:0] mdl [int];
	sba_arbiter #(.MEM_AW(10)) i_dut (
		.clk_in(clk_in), .resetn_in(resetn_in), .cfg_id_in(3'h1), .cfg_rotating_in(cfg_rotating_in),
		.cfg_host16_in(cfg_host16_in), .core_req_in(core_req_in), .core_lock_in(core_lock_in),
		.bus_req_in({peer_req, bus_req_out}), .host_bus_request_n_in(hbr_n), .chip_select_n_in(cs_n),
		.rd_n_in(rd_n), .wr_n_in(wr_n), .addr_in(addr), .data_in(wdata), .bus_req_out(bus_req_out),
		.bus_master_out(bus_master_out), .host_bus_grant_n_out(grant_n), .host_bus_grant_oe_out(grant_oe),
		.host_ready_out(rdy), .host_ready_oe_out(rdy_oe), .access_ack_out(ack), .access_ack_oe_out(ack_oe),
		.data_out(rdata), .data_oe_out(rdata_oe), .vector_irq_out(irq), .vector_addr_out(vec),
		.dma_enable_out(dma));
	sba_far_model i_far (
		.clk_in(clk_in), .grant_n_in(grant_w), .ack_in(ack_w), .rdata_in(rdata), .hbr_n_out(hbr_n),
		.cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .addr_out(addr), .data_out(wdata),
		.peer_req_out(peer_req));
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	always @(posedge clk_in) if (irq === 1'b1) irq_cnt++;
	always @(posedge clk_in) if (rdy_oe === 1'b1 && rdy === 1'b0) rdy_cnt++;
	function automatic logic [20:0] ma(input logic [3:0] f, input logic m, input logic [9:0] w);
		return {f, m, 6'h00, w};
	endfunction
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic need(input bit c);
		if (!c) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=0 exp=1 wait ran out", $time);
			final_report;
		end
	endtask
	task automatic wr(input bit h, input logic [20:0] a, input logic [31:0] v);
		i_far.xfer(1'b0, h, a, v, q, ok);
		need(ok);
	endtask
	task automatic rd(input bit h, input logic [20:0] a, input logic [31:0] e, input logic [31:0] m);
		int j;
		j = rdy_cnt;
		i_far.xfer(1'b1, h, a, 32'h0, q, ok);
		need(ok);
		chk(q & m, e);
		chk(rdy_cnt - j, h);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	initial begin
		seed = 32'h0778;
		resetn_in = 1'b0;
		{core_req_in, core_lock_in, cfg_rotating_in, cfg_host16_in} = 4'h0;
		repeat (20) @(negedge clk_in);
		chk({grant_n, ack_oe, rdata_oe, irq, bus_master_out}, 32'h10);
		resetn_in = 1'b1;
		repeat (4) @(negedge clk_in);
		core_lock_in = 1'b1;
		core_req_in = 1'b1;
		i_far.peer(5'h02);
		repeat (8) @(negedge clk_in);
		chk(bus_master_out, 1);
		chk(bus_req_out, 1);
		i_far.host_get(1'b1, 12, ok);
		chk(ok, 0);
		i_far.peer(5'h00);
		core_lock_in = 1'b0;
		core_req_in = 1'b0;
		for (i = 0; i < 20 && bus_master_out === 1'b1; i++) @(negedge clk_in);
		need(bus_master_out === 1'b0);
		chk(grant_w, 0);
		done("arbitration");
		for (i = 0; i < 4; i++) begin
			ta = ma(4'h0, 1'b1, 10'($random(seed)));
			d = $random(seed);
			mdl[ta[9:0]] = d;
			wr(1'b1, ta, d);
		end
		foreach (mdl[k]) rd(1'b1, ma(4'h0, 1'b1, k[9:0]), mdl[k], '1);
		d = $random(seed);
		wr(1'b1, ma(4'h0, 1'b0, {6'h00, `SBA_DMA_CTRL_OFS}), d);
		chk(dma, d[3:0]);
		i = irq_cnt;
		wr(1'b1, ma(4'h0, 1'b0, {6'h00, `SBA_VECTOR_OFS}), d);
		chk(irq_cnt, i + 1);
		chk(vec, d);
		wr(1'b1, ma(4'h0, 1'b0, {6'h00, `SBA_MBOX1_OFS}), ~d);
		rd(1'b1, ma(4'h0, 1'b0, {6'h00, `SBA_MBOX1_OFS}), ~d, '1);
		done("host access");
		cfg_host16_in = 1'b1;
		repeat (4) @(negedge clk_in);
		ta = ma(4'h0, 1'b1, 10'h3FF);
		d = $random(seed);
		wr(1'b1, ta, {16'h0, d[15:0]});
		wr(1'b1, ta, {16'h0, d[31:16]});
		rd(1'b1, ta, {16'h0, d[15:0]}, 32'h0000FFFF);
		rd(1'b1, ta, {16'h0, d[31:16]}, 32'h0000FFFF);
		cfg_host16_in = 1'b0;
		repeat (4) @(negedge clk_in);
		rd(1'b1, ta, d, '1);
		done("host 16-bit");
		i_far.host_get(1'b0, 0, ok);
		cfg_rotating_in = 1'b1;
		for (int p = 2; p <= 6; p++) begin
			i_far.peer(5'(1 << (p - 2)));
			repeat (6) @(negedge clk_in);
			chk(bus_master_out, 0);
			ta = ma(`SBA_BCAST_SPACE, 1'b1, 10'($random(seed)));
			d = $random(seed);
			wr(1'b0, ta, d);
			rd(1'b0, ma(4'h1, 1'b1, ta[9:0]), d, '1);
		end
		i_far.xfer(1'b1, 1'b0, ma(4'h2, 1'b1, 10'h000), 32'h0, q, ok);
		chk(ok, 0);
		i_far.peer(5'h00);
		done("peers");
		final_report;
	end
endmodule
